// >>> tac_pkg.sv
// constants shared by the timing, alarm and test control block
// assumes a 100 MHz clock and a 32-bit Avalon-MM register slave
//
// Functional notes
// - one configured master source times everything
// - output clocks keep own rates regardless
// - failed master clock falls back to internal
// - drop/insert source needs multi-port and enable
// - drop/insert disabled moves source to network
// - only first data port may be source
// - external clock source on multi-port units only
// - external rate 2048, 1544 or 8 kHz
// - external rate applies only with external source
// - yellow enabled sends yellow on both sides
// - yellow disabled turns network yellow into AIS
// - drop/insert disabled forces network yellow generation
// - timeout enabled ends tests after duration
// - timeout disabled tests run until stopped
// - duration 1 to 120 minutes, default 10
// - up/down edit a digit, save commits
package tac_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DUR = 4'h4;
  localparam logic [3:0] ADDR_TEST = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int F_SRC_LSB = 0;
  localparam int F_DROP_EN = 3;
  localparam int F_GEN_YEL = 4;
  localparam int F_TST_TO = 5;
  localparam int F_RATE_LSB = 6;
  localparam int F_UP = 0;
  localparam int F_DOWN = 1;
  localparam int F_SAVE = 2;
  localparam int F_DIG_LSB = 3;
  localparam int F_COMMIT_LSB = 8;
  localparam int F_START = 0;
  localparam int F_STOP = 1;
  localparam int F_MINS_LSB = 8;
  localparam int F_FLAG = 0;
  localparam int F_EFF_LSB = 1;
  localparam int F_VAR_LSB = 4;
  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [2:0] SRC_NET = 3'h0;
  localparam logic [2:0] SRC_DROP = 3'h1;
  localparam logic [2:0] SRC_PORT1 = 3'h2;
  localparam logic [2:0] SRC_INT = 3'h3;
  localparam logic [2:0] SRC_EXT = 3'h4;
  localparam logic [1:0] RATE_2048 = 2'h0;
  localparam logic [1:0] RATE_1544 = 2'h1;
  localparam logic [1:0] RATE_8 = 2'h2;
  localparam logic [1:0] VAR_1PORT = 2'h0;
  localparam logic [1:0] DIG_ONES = 2'h0;
  localparam logic [1:0] DIG_TENS = 2'h1;
  localparam logic [1:0] DIG_HUNDREDS = 2'h2;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] RST_SRC = SRC_NET;
  localparam logic [1:0] RST_RATE = RATE_1544;
  localparam logic RST_DROP_EN = 1'h1;
  localparam logic RST_GEN_YEL = 1'h1;
  localparam logic RST_TST_TO = 1'h1;
  localparam logic [7:0] RST_DUR = 8'h0A;
  localparam logic [7:0] DUR_MIN = 8'h01;
  localparam logic [7:0] DUR_MAX = 8'h78;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ = 100_000_000;
  localparam longint MINUTE_S = 60;
  localparam longint CYC_PER_MIN = CLK_HZ * MINUTE_S;
  // test state, one-hot
  typedef enum logic [1:0] {T_IDLE = 2'b01, T_RUN = 2'b10} test_st_t;
endpackage

// >>> tac_sync3.sv
// three-stage synchroniser bank for pin-level inputs
// assumes inputs are slow levels from outside the clock domain
`timescale 1ns/1ps
module tac_sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // all stages in one packed state
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;
  sync_t st_r;
  sync_t st_nxt;
  // ----------------------------------------
  // next state: a change counts once stages two and three agree
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end
  // registered copy, frozen while enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.q;
endmodule

// >>> timing_alarm_test_control.sv
// master timing select, yellow alarm policy and test timer
// assumes an Avalon-MM master and clock-presence levels from pins
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module timing_alarm_test_control #(
  parameter logic [32:0] P_CYC_PER_MIN = 33'(tac_pkg::CYC_PER_MIN)
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [1:0] i_variant,
  input wire logic i_net_clk_ok,
  input wire logic i_drop_clk_ok,
  input wire logic i_port1_clk_ok,
  input wire logic i_ext_clk_ok,
  input wire logic i_net_yellow_rx,
  input wire logic i_net_rx_fail,
  input wire logic i_drop_rx_fail,
  output logic [4:0] o_master_sel,
  output logic [1:0] o_ext_rate,
  output logic o_ext_rate_valid,
  output logic o_net_yellow_tx,
  output logic o_drop_yellow_tx,
  output logic o_drop_ais_tx,
  output logic o_test_active,
  output logic o_fallback
);
  import tac_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [8:0] sy; // synced pins
  logic [1:0] variant; // unit variant strap
  logic net_ok, drop_ok, p1_ok, ext_ok; // clock presence
  logic yel_rx, net_fail, drop_fail; // line conditions

  tac_sync3 #(.W(9)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_d({i_variant, i_net_clk_ok, i_drop_clk_ok, i_port1_clk_ok, i_ext_clk_ok,
          i_net_yellow_rx, i_net_rx_fail, i_drop_rx_fail}),
    .o_q(sy)
  );
  assign {variant, net_ok, drop_ok, p1_ok, ext_ok, yel_rx, net_fail, drop_fail} = sy;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] cfg_src; // configured master source
    logic drop_en; // drop/insert interface enabled
    logic gen_yel; // yellow generation setting
    logic tst_to; // test timeout enabled
    logic [1:0] rate; // external clock rate
    logic fb_act; // fallback in force
    logic fb_flag; // sticky fallback flag
    logic [7:0] dur_pend; // duration being edited
    logic [7:0] dur_commit; // saved duration
    logic [1:0] digit; // digit under edit
    test_st_t tst; // test timer state
    logic [32:0] cyc; // cycles within current minute
    logic [7:0] mins; // whole minutes elapsed
    logic wait_r; // waitrequest flop
    logic [31:0] rdata; // read data flop
    logic [4:0] msel; // one-hot master select
    logic rate_vld; // rate in force
    logic net_yel; // yellow toward network
    logic drop_yel; // yellow toward drop/insert
    logic drop_ais; // AIS toward drop/insert
  } st_t;
  st_t st_r;
  st_t st_nxt;

  // bus decode helpers
  logic acc; // access completes at next edge
  logic wr_ctrl, wr_dur, wr_test, wr_stat;
  logic multi; // two- or four-port unit
  logic sel_ok; // selected master clock present
  logic gen_eff; // effective yellow generation
  logic [7:0] step; // digit weight
  logic [8:0] sum; // widened edit value
  logic [2:0] wsrc; // requested source
  logic [1:0] wrate; // requested rate
  logic [7:0] mins_inc; // minutes after this tick

  always_comb begin
    acc = (i_avs_read | i_avs_write) & ~st_r.wait_r;
    wr_ctrl = acc & i_avs_write & i_avs_byteenable[0] & (i_avs_address == ADDR_CTRL);
    wr_dur = acc & i_avs_write & i_avs_byteenable[0] & (i_avs_address == ADDR_DUR);
    wr_test = acc & i_avs_write & i_avs_byteenable[0] & (i_avs_address == ADDR_TEST);
    wr_stat = acc & i_avs_write & i_avs_byteenable[0] & (i_avs_address == ADDR_STAT);
    multi = (variant != VAR_1PORT);
    wsrc = i_avs_writedata[F_SRC_LSB +: 3];
    wrate = i_avs_writedata[F_RATE_LSB +: 2];
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    step = 8'h01;
    sum = 9'h000;
    sel_ok = 1'b1;
    gen_eff = 1'b1;
    mins_inc = st_r.mins + 8'h01;
    // one wait cycle, then the access completes
    st_nxt.wait_r = ~((i_avs_read | i_avs_write) & st_r.wait_r);
    // control write: illegal source codes are refused
    if (wr_ctrl) begin
      st_nxt.drop_en = i_avs_writedata[F_DROP_EN] & multi;
      st_nxt.gen_yel = i_avs_writedata[F_GEN_YEL];
      st_nxt.tst_to = i_avs_writedata[F_TST_TO];
      case (wsrc)
        SRC_NET, SRC_INT, SRC_PORT1: begin
          st_nxt.cfg_src = wsrc;
        end
        SRC_DROP: begin
          if (multi && i_avs_writedata[F_DROP_EN]) begin
            st_nxt.cfg_src = wsrc;
          end
        end
        SRC_EXT: begin
          if (multi) begin
            st_nxt.cfg_src = wsrc;
          end
        end
        default: begin
          st_nxt.cfg_src = st_r.cfg_src;
        end
      endcase
      // rate only taken with external source chosen, code 3 refused
      if (st_nxt.cfg_src == SRC_EXT && wrate != 2'h3) begin
        st_nxt.rate = wrate;
      end
      // a fresh choice retries the configured source
      st_nxt.fb_act = 1'b0;
    end
    // disabling drop/insert takes the source back to the network
    if (!st_nxt.drop_en && st_nxt.cfg_src == SRC_DROP) begin
      st_nxt.cfg_src = SRC_NET;
    end
    // presence of the selected clock
    case (st_nxt.cfg_src)
      SRC_NET: sel_ok = net_ok;
      SRC_DROP: sel_ok = drop_ok;
      SRC_PORT1: sel_ok = p1_ok;
      SRC_EXT: sel_ok = ext_ok;
      default: sel_ok = 1'b1;
    endcase
    // status write-one-to-clear first, so a new fallback wins
    if (wr_stat && i_avs_writedata[F_FLAG]) begin
      st_nxt.fb_flag = 1'b0;
    end
    if (!sel_ok && st_nxt.cfg_src != SRC_INT) begin
      st_nxt.fb_act = 1'b1;
      st_nxt.fb_flag = 1'b1;
    end
    // one master drives all timing; output synthesisers keep own rates
    if (st_nxt.fb_act) begin
      st_nxt.msel = 5'h01 << SRC_INT;
    end else begin
      st_nxt.msel = 5'h01 << st_nxt.cfg_src;
    end
    st_nxt.rate_vld = st_nxt.msel[SRC_EXT];
    // yellow policy; without drop/insert the setting is moot
    gen_eff = st_nxt.drop_en ? st_nxt.gen_yel : 1'b1;
    st_nxt.net_yel = gen_eff & net_fail;
    st_nxt.drop_yel = gen_eff & st_nxt.drop_en & drop_fail;
    st_nxt.drop_ais = ~gen_eff & st_nxt.drop_en & yel_rx;
    // duration editing, clamped into range
    if (wr_dur) begin
      if (i_avs_writedata[F_DIG_LSB +: 2] != 2'h3) begin
        st_nxt.digit = i_avs_writedata[F_DIG_LSB +: 2];
      end
      case (st_nxt.digit)
        DIG_TENS: step = 8'h0A;
        DIG_HUNDREDS: step = 8'h64;
        default: step = 8'h01;
      endcase
      if (i_avs_writedata[F_SAVE]) begin
        st_nxt.dur_commit = st_r.dur_pend;
      end
      if (i_avs_writedata[F_UP]) begin
        sum = {1'b0, st_r.dur_pend} + {1'b0, step};
        st_nxt.dur_pend = (sum > {1'b0, DUR_MAX}) ? DUR_MAX : sum[7:0];
      end else if (i_avs_writedata[F_DOWN]) begin
        sum = {1'b0, st_r.dur_pend} - {1'b0, step};
        st_nxt.dur_pend = (st_r.dur_pend <= step) ? DUR_MIN : sum[7:0];
      end
    end
    // test timer
    case (st_r.tst)
      T_IDLE: begin
        if (wr_test && i_avs_writedata[F_START]) begin
          st_nxt.tst = T_RUN;
          st_nxt.cyc = '0;
          st_nxt.mins = '0;
        end
      end
      T_RUN: begin
        st_nxt.cyc = st_r.cyc + 33'h1;
        if (st_r.cyc == P_CYC_PER_MIN - 33'h1) begin
          st_nxt.cyc = '0;
          st_nxt.mins = mins_inc;
          if (st_r.tst_to && mins_inc >= st_r.dur_commit) begin
            st_nxt.tst = T_IDLE;
          end
        end
        // without timeout only a stop ends the test
        if (wr_test && i_avs_writedata[F_STOP]) begin
          st_nxt.tst = T_IDLE;
        end
      end
      default: begin
        st_nxt.tst = T_IDLE;
      end
    endcase
    // read data captured in the wait cycle
    if ((i_avs_read | i_avs_write) && st_r.wait_r) begin
      st_nxt.rdata = 32'h0;
      case (i_avs_address)
        ADDR_CTRL: begin
          st_nxt.rdata[F_SRC_LSB +: 3] = st_r.cfg_src;
          st_nxt.rdata[F_DROP_EN] = st_r.drop_en;
          st_nxt.rdata[F_GEN_YEL] = st_r.gen_yel;
          st_nxt.rdata[F_TST_TO] = st_r.tst_to;
          st_nxt.rdata[F_RATE_LSB +: 2] = st_r.rate;
        end
        ADDR_DUR: begin
          st_nxt.rdata[7:0] = st_r.dur_pend;
          st_nxt.rdata[F_COMMIT_LSB +: 8] = st_r.dur_commit;
          st_nxt.rdata[F_DIG_LSB + 16 +: 2] = st_r.digit;
        end
        ADDR_TEST: begin
          st_nxt.rdata[0] = (st_r.tst == T_RUN);
          st_nxt.rdata[F_MINS_LSB +: 8] = st_r.mins;
        end
        ADDR_STAT: begin
          st_nxt.rdata[F_FLAG] = st_r.fb_flag;
          st_nxt.rdata[F_EFF_LSB +: 3] = st_r.fb_act ? SRC_INT : st_r.cfg_src;
          st_nxt.rdata[F_VAR_LSB +: 2] = variant;
        end
        default: begin
          st_nxt.rdata = 32'h0; // unmapped reads as zero
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register, frozen while enable is low
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.cfg_src <= RST_SRC;
      st_r.drop_en <= RST_DROP_EN;
      st_r.gen_yel <= RST_GEN_YEL;
      st_r.tst_to <= RST_TST_TO;
      st_r.rate <= RST_RATE;
      st_r.dur_pend <= RST_DUR;
      st_r.dur_commit <= RST_DUR;
      st_r.tst <= T_IDLE;
      st_r.wait_r <= 1'b1;
      st_r.msel <= 5'h01;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = st_r.wait_r;
  assign o_master_sel = st_r.msel;
  assign o_ext_rate = st_r.rate;
  assign o_ext_rate_valid = st_r.rate_vld;
  assign o_net_yellow_tx = st_r.net_yel;
  assign o_drop_yellow_tx = st_r.drop_yel;
  assign o_drop_ais_tx = st_r.drop_ais;
  assign o_test_active = st_r.tst[1]; // run bit of the one-hot state flop
  assign o_fallback = st_r.fb_flag;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_master_onehot: assert property ($onehot(o_master_sel))
    else $error("master select not one-hot");
  a_fallback_int: assert property (i_ce && !sel_ok && st_nxt.cfg_src != SRC_INT
    |=> o_master_sel[SRC_INT] && st_r.fb_act)
    else $error("no fallback to internal clock");
  a_drop_needs_en: assert property (st_r.cfg_src == SRC_DROP |-> st_r.drop_en)
    else $error("drop source while drop disabled");
  a_ext_single: assert property (i_ce && wr_ctrl && wsrc == SRC_EXT && !multi
    |=> st_r.cfg_src == $past(st_r.cfg_src))
    else $error("external source on single-port unit");
  a_rate_legal: assert property (st_r.rate != 2'h3)
    else $error("illegal external rate");
  a_rate_gated: assert property (o_ext_rate_valid == (st_r.cfg_src == SRC_EXT && !st_r.fb_act))
    else $error("rate valid without external source");
  a_yel_forced: assert property (i_ce && !st_nxt.drop_en && net_fail
    |=> o_net_yellow_tx && !o_drop_ais_tx)
    else $error("yellow not forced with drop disabled");
  a_ais_policy: assert property (o_drop_ais_tx |-> !o_drop_yellow_tx
    && st_r.drop_en && !st_r.gen_yel)
    else $error("AIS sent with yellow generation on");
  a_test_ends: assert property (i_ce && st_r.tst == T_RUN && st_r.tst_to
    && st_r.cyc == P_CYC_PER_MIN - 33'h1 && mins_inc >= st_r.dur_commit |=> !o_test_active)
    else $error("test did not time out");
  a_test_holds: assert property (i_ce && st_r.tst == T_RUN && !st_r.tst_to && !wr_test
    |=> o_test_active)
    else $error("test ended without stop");
  a_dur_range: assert property (st_r.dur_pend >= DUR_MIN && st_r.dur_pend <= DUR_MAX
    && st_r.dur_commit >= DUR_MIN && st_r.dur_commit <= DUR_MAX)
    else $error("duration out of range");
  a_save_commit: assert property (i_ce && wr_dur && i_avs_writedata[F_SAVE]
    |=> st_r.dur_commit == $past(st_r.dur_pend))
    else $error("save did not commit");
  a_flag_sticky: assert property (o_fallback && !(i_ce && wr_stat) |=> o_fallback)
    else $error("fallback flag lost");
endmodule

// >>> line_partner.sv
// far-side model: network line and drop/insert terminal equipment
// assumes the bench chooses which clocks die and which alarms arrive
`timescale 1ns/1ps
module line_partner (
  input wire logic i_clk,
  input wire logic [3:0] i_dead,
  input wire logic i_yel,
  input wire logic [1:0] i_fail,
  output logic o_net_clk_ok,
  output logic o_drop_clk_ok,
  output logic o_port1_clk_ok,
  output logic o_ext_clk_ok,
  output logic o_net_yellow,
  output logic [1:0] o_rx_fail
);
  // ----------------------------------------
  // line state
  // ----------------------------------------
  // bit order: fail[1:0], yellow, ext, port1, drop, net clock present
  logic [6:0] st_r = 7'h0F;
  // levels move one edge after the bench asks, as a real line drops out
  // port1 equipment clocks 8 kbps low with the data link on; only presence is modelled
  // with generation off the drop side equipment sends yellow itself; here it is a level
  always @(posedge i_clk) begin
    st_r <= {i_fail, i_yel, ~i_dead};
  end
  assign o_net_clk_ok = st_r[0];
  assign o_drop_clk_ok = st_r[1];
  assign o_port1_clk_ok = st_r[2];
  assign o_ext_clk_ok = st_r[3];
  assign o_net_yellow = st_r[4];
  assign o_rx_fail = st_r[6:5];
endmodule

// >>> tb_timing_alarm_test_control.sv
// bench for the timing, alarm and test control block
// assumes a 100 MHz clock and a shortened minute of MIN_CYC cycles
`timescale 1ns/1ps
module tb_timing_alarm_test_control;
  import tac_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int MIN_CYC = 20; // short minute keeps timed tests brief
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] variant = 2'h1; // multi-port unit to begin with
  logic [3:0] dead = 4'h0;
  logic yel = 1'b0;
  logic [1:0] fail = 2'h0;
  logic net_ok, drop_ok, p1_ok, ext_ok, yel_rx;
  logic [1:0] rx_fail;
  logic [4:0] msel;
  logic [1:0] xrate;
  logic xvalid, net_y, drop_y, ais, active, fb;
  logic [31:0] q;
  int n_fail = 0;
  int n_checks = 0;
  int k;

  always #5 clk = ~clk;

  line_partner line (.i_clk(clk), .i_dead(dead), .i_yel(yel), .i_fail(fail),
    .o_net_clk_ok(net_ok), .o_drop_clk_ok(drop_ok), .o_port1_clk_ok(p1_ok),
    .o_ext_clk_ok(ext_ok), .o_net_yellow(yel_rx), .o_rx_fail(rx_fail));

  timing_alarm_test_control #(.P_CYC_PER_MIN(33'(MIN_CYC))) uut (.i_clk(clk),
    .i_rst_n(rst_n), .i_ce(ce), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_variant(variant),
    .i_net_clk_ok(net_ok), .i_drop_clk_ok(drop_ok), .i_port1_clk_ok(p1_ok),
    .i_ext_clk_ok(ext_ok), .i_net_yellow_rx(yel_rx), .i_net_rx_fail(rx_fail[0]),
    .i_drop_rx_fail(rx_fail[1]), .o_master_sel(msel), .o_ext_rate(xrate),
    .o_ext_rate_valid(xvalid), .o_net_yellow_tx(net_y), .o_drop_yellow_tx(drop_y),
    .o_drop_ais_tx(ais), .o_test_active(active), .o_fallback(fb));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // one access; held until waitrequest is seen low, a stuck slave ends the run
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      $display("wrong value at %0t: bus never answered", $time);
      summarize();
    end
  endtask

  function automatic logic [31:0] ctl(logic [2:0] s, logic d, logic g, logic t,
      logic [1:0] r);
    return {24'h0, r, t, g, d, s};
  endfunction

  // control write, then time for pin syncs and registered outputs to follow
  task automatic set(input logic [2:0] s, input logic d, input logic g, input logic t,
      input logic [1:0] r);
    bus(1'b1, ADDR_CTRL, ctl(s, d, g, t, r));
    repeat (6) @(posedge clk);
  endtask

  // duration command, then read back the pending value
  task automatic dur(input logic [4:0] c, input logic [7:0] pend);
    bus(1'b1, ADDR_DUR, 32'(c));
    bus(1'b0, ADDR_DUR, 32'h0);
    chk(32'(q[7:0]), 32'(pend), "pending duration");
  endtask

  // watchdog: a hang counts as a mismatch and ends in the report
  initial begin
    #900000;
    n_fail++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(q & 32'hFF, ctl(RST_SRC, RST_DROP_EN, RST_GEN_YEL, RST_TST_TO, RST_RATE), "ctrl");
    bus(1'b0, ADDR_DUR, 32'h0);
    chk(32'(q[15:0]), {16'h0, RST_DUR, RST_DUR}, "duration reset");
    // syncs start at zero, so a startup fallback is expected; retry and clear it
    repeat (8) @(posedge clk);
    set(SRC_NET, 1'b1, 1'b1, 1'b1, RATE_1544);
    bus(1'b1, ADDR_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'({fb, msel}), 32'h01, "network master");
    // every legal source on a multi-port unit
    for (int s = 0; s < 5; s++) begin
      set(3'(s), 1'b1, 1'b1, 1'b1, RATE_1544);
      chk(32'(msel), 32'h1 << s, "master select");
      chk(32'(xvalid), 32'(s == 4), "rate offered");
    end
    // every rate code on the external source; code 3 is refused
    for (int r = 0; r < 4; r++) begin
      set(SRC_EXT, 1'b1, 1'b1, 1'b1, 2'(r));
      chk(32'(xrate), (r == 3) ? 32'(RATE_8) : 32'(r), "external rate");
    end
    set(3'h5, 1'b1, 1'b1, 1'b1, RATE_8);
    chk(32'(msel), 32'h10, "illegal source");
    // selected clock dies: internal takes over, flag is sticky
    set(SRC_PORT1, 1'b1, 1'b1, 1'b1, RATE_1544);
    chk(32'({xvalid, xrate}), 32'(RATE_8), "rate kept off external");
    dead <= 4'h4;
    k = 0;
    while (msel !== 5'h08 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk(32'(msel), 32'h08, "fallback to internal");
    dead <= 4'h0;
    repeat (8) @(posedge clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk(32'(q[3:0]), 32'({SRC_INT, 1'b1}), "status after fallback");
    bus(1'b1, ADDR_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(fb), 32'h0, "flag cleared");
    // drop/insert chosen, then disabled: network takes over
    set(SRC_DROP, 1'b1, 1'b1, 1'b1, RATE_1544);
    chk(32'(msel), 32'h02, "drop master");
    set(SRC_DROP, 1'b0, 1'b1, 1'b1, RATE_1544);
    chk(32'(msel), 32'h01, "drop disabled");
    // alarm policy with generation on, then off
    set(SRC_NET, 1'b1, 1'b1, 1'b1, RATE_1544);
    fail <= 2'h3;
    yel <= 1'b1;
    repeat (7) @(posedge clk);
    chk(32'({net_y, drop_y, ais}), 32'h6, "yellow both sides");
    set(SRC_NET, 1'b1, 1'b0, 1'b1, RATE_1544);
    chk(32'({net_y, drop_y, ais}), 32'h1, "ais instead");
    // single-port unit: no drop/insert, no external source, yellow forced
    variant <= 2'h0;
    repeat (8) @(posedge clk);
    set(SRC_NET, 1'b1, 1'b0, 1'b1, RATE_1544);
    chk(32'(net_y), 32'h1, "forced yellow");
    set(SRC_DROP, 1'b1, 1'b1, 1'b1, RATE_1544);
    chk(32'(msel), 32'h01, "drop refused");
    set(SRC_EXT, 1'b1, 1'b1, 1'b1, RATE_1544);
    chk(32'(msel), 32'h01, "external refused");
    variant <= 2'h1;
    fail <= 2'h0;
    yel <= 1'b0;
    repeat (8) @(posedge clk);
    // duration editing: digits, clamps at both ends, save
    dur({DIG_ONES, 3'h1}, 8'h0B);
    dur({DIG_ONES, 3'h4}, 8'h0B);
    chk(32'(q[15:8]), 32'h0B, "saved");
    dur({DIG_TENS, 3'h2}, 8'h01);
    dur({DIG_ONES, 3'h2}, DUR_MIN);
    dur({DIG_HUNDREDS, 3'h1}, 8'h65);
    dur({DIG_TENS, 3'h1}, 8'h6F);
    dur({DIG_TENS, 3'h1}, DUR_MAX);
    chk(32'(q[15:8]), 32'h0B, "unsaved edit");
    dur({DIG_HUNDREDS, 3'h2}, 8'h14);
    dur({DIG_TENS, 3'h2}, 8'h0A);
    dur({DIG_TENS, 3'h2}, DUR_MIN);
    dur({DIG_ONES, 3'h1}, 8'h02);
    dur({DIG_ONES, 3'h4}, 8'h02);
    dur({2'h3, 3'h1}, 8'h03);
    // timed test of two minutes ends by itself
    set(SRC_NET, 1'b1, 1'b1, 1'b1, RATE_1544);
    bus(1'b1, ADDR_TEST, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(active), 32'h1, "test started");
    k = 0;
    while (active === 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k >= 2 * MIN_CYC - 4 && k <= 3 * MIN_CYC + 4), 32'h1, "timed end");
    // untimed test stays until stopped
    set(SRC_NET, 1'b1, 1'b1, 1'b0, RATE_1544);
    bus(1'b1, ADDR_TEST, 32'h1);
    repeat (8 * MIN_CYC) @(posedge clk);
    chk(32'(active), 32'h1, "untimed still on");
    bus(1'b1, ADDR_TEST, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(active), 32'h0, "manual stop");
    // enable low freezes all state, so a brief clock loss goes unseen
    ce <= 1'b0;
    dead <= 4'h1;
    repeat (10) @(posedge clk);
    dead <= 4'h0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({fb, msel}), 32'h01, "frozen by enable");
    // stray accesses answer and change nothing
    bus(1'b0, 4'h2, 32'h0);
    bus(1'b1, 4'h2, 32'hFF);
    repeat (2) @(posedge clk);
    chk(32'(msel), 32'h01, "unmapped access");
    summarize();
  end
endmodule
